/* hdl/flc_top.sv */
`timescale 1ns/1ps
`include "flc_defines.svh"
//
// Contract
// - Reference from master/bit/frame clock, prediv 1..8
// - Control block clock is oscillator over rate+1
// - Output clock is oscillator over 2..256
// - Feedback ratio 1,2,4,8, top bit 16
// - Fraction is 16 bits, MSB weighs half
// - Integer multiplier is 10 bits, LSB one
// - Route bit selects ADC or digital microphone
// - Mode bit selects integer or fractional multiply
module flc_top #(
	parameter int PERIOD_W = 16
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regRdata,
	input  wire logic        masterClockIn,
	input  wire logic        bitClockIn,
	input  wire logic        frameClockIn,
	output logic             oscillatorTick,
	output logic             loopCtrlTick,
	output logic             loopOutputClock,
	output logic             dspInputDmicSel
);

	flc_pkg::flc_reg_req_t  req;
	flc_pkg::flc_div_ctrl_t divCtrl;
	logic [15:0]            loopMultFraction;
	logic [9:0]             loopMultInteger;
	logic                   loopFractionalMode;
	logic                   loopEnable;
	logic [2:0]             syncA;
	logic [2:0]             syncB;
	logic                   refLevel;
	logic                   refLast;
	logic                   refEdge;
	logic [2:0]             preCnt;
	logic [2:0]             preMask;
	logic                   refTick;
	logic [PERIOD_W-1:0]    periodCnt;
	logic [PERIOD_W-1:0]    period;
	logic [39:0]            phaseAcc;
	logic [39:0]            phaseLimit;
	logic [39:0]            phaseStep;
	logic [39:0]            next_phaseAcc;
	logic                   next_oscTick;
	logic [2:0]             ctrlCnt;
	logic [7:0]             outCnt;

	assign req = '{write: regWrite, read: regRead, addr: regAddr, wdata: regWdata};

	function automatic logic [2:0] flc_fratio_shift(input logic [2:0] code);
		if (code[2]) begin
			return 3'h4;
		end
		return {1'b0, code[1:0]};
	endfunction

	// Register writes
	always_ff @(posedge clock) begin
		if (rst) begin
			divCtrl            <= `FLC_RST_DIVIDER;
			loopMultFraction   <= `FLC_RST_FRACTION;
			loopMultInteger    <= `FLC_RST_INTEGER;
			dspInputDmicSel    <= `FLC_RST_ROUTE;
			loopFractionalMode <= `FLC_RST_FRAC_MODE;
			loopEnable         <= `FLC_RST_ENABLE;
		end else if (req.write) begin
			unique case (req.addr)
				`FLC_ADDR_LOOP_CONTROL: begin
					loopFractionalMode <= req.wdata[`FLC_FRAC_MODE_BIT];
					loopEnable         <= req.wdata[`FLC_ENABLE_BIT];
				end
				`FLC_ADDR_DIVIDER_CONTROL: begin
					divCtrl <= req.wdata[`FLC_SRC_MSB:`FLC_FRATIO_LSB];
				end
				`FLC_ADDR_FRACTION_MULT: begin
					loopMultFraction <= req.wdata;
				end
				`FLC_ADDR_INTEGER_MULT: begin
					loopMultInteger <= req.wdata[`FLC_INT_MSB:0];
				end
				`FLC_ADDR_INPUT_ROUTE: begin
					dspInputDmicSel <= req.wdata[`FLC_ROUTE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, data in the following cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			regRdata <= 16'h0000;
		end else if (req.read) begin
			unique case (req.addr)
				`FLC_ADDR_LOOP_CONTROL: begin
					regRdata <= 16'h0000;
					regRdata[`FLC_FRAC_MODE_BIT] <= loopFractionalMode;
					regRdata[`FLC_ENABLE_BIT]    <= loopEnable;
				end
				`FLC_ADDR_DIVIDER_CONTROL: begin
					regRdata <= {3'h0, divCtrl};
				end
				`FLC_ADDR_FRACTION_MULT: begin
					regRdata <= loopMultFraction;
				end
				`FLC_ADDR_INTEGER_MULT: begin
					regRdata <= {6'h00, loopMultInteger};
				end
				`FLC_ADDR_INPUT_ROUTE: begin
					regRdata <= 16'h0000;
					regRdata[`FLC_ROUTE_BIT] <= dspInputDmicSel;
				end
				default: begin
					regRdata <= 16'h0000;
				end
			endcase
		end else begin
			regRdata <= 16'h0000;
		end
	end

	// Two-stage synchronisers for the reference clock pins
	always_ff @(posedge clock) begin
		if (rst) begin
			syncA <= 3'h0;
			syncB <= 3'h0;
		end else begin
			syncA <= {frameClockIn, bitClockIn, masterClockIn};
			syncB <= syncA;
		end
	end

	// Reference source selection, reserved code gives no reference
	always_comb begin
		unique case (divCtrl.loopRefSourceSel)
			`FLC_SRC_MASTER: refLevel = syncB[0];
			`FLC_SRC_BIT:    refLevel = syncB[1];
			`FLC_SRC_FRAME:  refLevel = syncB[2];
			default:         refLevel = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			refLast <= 1'b0;
		end else begin
			refLast <= refLevel;
		end
	end

	assign refEdge = refLevel & ~refLast;

	// Reference pre-divider by 1, 2, 4 or 8
	assign preMask = 3'((4'h1 << divCtrl.loopRefPrediv) - 4'h1);
	assign refTick = refEdge & ((preCnt & preMask) == preMask);

	always_ff @(posedge clock) begin
		if (rst || !loopEnable) begin
			preCnt <= 3'h0;
		end else if (refEdge) begin
			preCnt <= 3'(preCnt + 3'h1);
		end
	end

	// Divided reference period in system clocks
	always_ff @(posedge clock) begin
		if (rst || !loopEnable) begin
			periodCnt <= '0;
			period    <= '0;
		end else if (refTick) begin
			periodCnt <= '0;
			period    <= PERIOD_W'(periodCnt + 1'b1);
		end else if (periodCnt != '1) begin
			periodCnt <= PERIOD_W'(periodCnt + 1'b1);
		end
	end

	// Oscillator ticks per reference period: ratio * (N + K/65536)
	always_comb begin
		phaseStep = {14'h0000, loopMultInteger, loopFractionalMode ? loopMultFraction : 16'h0000};
		phaseStep = phaseStep << flc_fratio_shift(divCtrl.loopFeedbackRatio);
		phaseLimit = 40'({period, {`FLC_FRAC_BITS{1'b0}}});
		next_phaseAcc = 40'(phaseAcc + phaseStep);
		next_oscTick = 1'b0;
		if (period == '0) begin
			next_phaseAcc = 40'h0;
		end else if (phaseStep >= phaseLimit) begin
			next_phaseAcc = 40'h0;
			next_oscTick  = 1'b1;
		end else if (next_phaseAcc >= phaseLimit) begin
			next_phaseAcc = 40'(next_phaseAcc - phaseLimit);
			next_oscTick  = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !loopEnable) begin
			phaseAcc       <= 40'h0;
			oscillatorTick <= 1'b0;
		end else begin
			phaseAcc       <= next_phaseAcc;
			oscillatorTick <= next_oscTick;
		end
	end

	// Control block rate divider
	always_ff @(posedge clock) begin
		if (rst || !loopEnable) begin
			ctrlCnt      <= 3'h0;
			loopCtrlTick <= 1'b0;
		end else if (oscillatorTick) begin
			loopCtrlTick <= (ctrlCnt == divCtrl.loopCtrlRateDiv);
			ctrlCnt      <= (ctrlCnt == divCtrl.loopCtrlRateDiv) ? 3'h0 : 3'(ctrlCnt + 3'h1);
		end else begin
			loopCtrlTick <= 1'b0;
		end
	end

	// Output divider by 2 to 256
	always_ff @(posedge clock) begin
		if (rst || !loopEnable) begin
			outCnt          <= 8'h00;
			loopOutputClock <= 1'b0;
		end else begin
			if (oscillatorTick) begin
				outCnt <= 8'(outCnt + 8'h01);
			end
			loopOutputClock <= outCnt[divCtrl.loopOutputDiv];
		end
	end

endmodule

/* hdl/flc_defines.svh */
`ifndef FLC_DEFINES_SVH
`define FLC_DEFINES_SVH

// Register offsets
`define FLC_ADDR_LOOP_CONTROL      8'h80
`define FLC_ADDR_DIVIDER_CONTROL   8'h81
`define FLC_ADDR_FRACTION_MULT     8'h82
`define FLC_ADDR_INTEGER_MULT      8'h83
`define FLC_ADDR_INPUT_ROUTE       8'ha4

// Loop control fields
`define FLC_ENABLE_BIT             0
`define FLC_FRAC_MODE_BIT          2

// Divider control fields
`define FLC_SRC_MSB                12
`define FLC_SRC_LSB                11
`define FLC_PREDIV_MSB             10
`define FLC_PREDIV_LSB             9
`define FLC_RATE_MSB               8
`define FLC_RATE_LSB               6
`define FLC_OUTDIV_MSB             5
`define FLC_OUTDIV_LSB             3
`define FLC_FRATIO_MSB             2
`define FLC_FRATIO_LSB             0

// Integer multiplier and route fields
`define FLC_INT_MSB                9
`define FLC_ROUTE_BIT              9

// Reference source codes
`define FLC_SRC_MASTER             2'h0
`define FLC_SRC_BIT                2'h1
`define FLC_SRC_FRAME              2'h2

// Reset values
`define FLC_RST_DIVIDER            13'h0000
`define FLC_RST_FRACTION           16'h0000
`define FLC_RST_INTEGER            10'h000
`define FLC_RST_ROUTE              1'b0
`define FLC_RST_FRAC_MODE          1'b0
`define FLC_RST_ENABLE             1'b0

// Fraction weight: 16 fractional bits
`define FLC_FRAC_BITS              16

`endif

/* hdl/flc_pkg.sv */
package flc_pkg;

	typedef struct packed {
		logic [1:0] loopRefSourceSel;
		logic [1:0] loopRefPrediv;
		logic [2:0] loopCtrlRateDiv;
		logic [2:0] loopOutputDiv;
		logic [2:0] loopFeedbackRatio;
	} flc_div_ctrl_t;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} flc_reg_req_t;

endpackage

/* testbench/flc_top_props.sv */
`timescale 1ns/1ps
module flc_top_props (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [7:0]  regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regRdata,
	input wire logic        oscillatorTick,
	input wire logic        loopCtrlTick,
	input wire logic        dspInputDmicSel
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 16'h0000)
		else $error("read data not idle");
	AST_ROUTE_WR: assert property (regWrite && regAddr == 8'ha4 |=> dspInputDmicSel == $past(regWdata[9]))
		else $error("route bit not written");
	AST_ROUTE_HOLD: assert property (!(regWrite && regAddr == 8'ha4) |=> $stable(dspInputDmicSel))
		else $error("route bit changed");
	AST_RD_UNMAPPED: assert property (regRead && regAddr == 8'h84 |=> regRdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_RD_INT: assert property (regRead && regAddr == 8'h83 |=> regRdata[15:10] == 6'h00)
		else $error("integer spare bits set");
	AST_RD_DIV: assert property (regRead && regAddr == 8'h81 |=> regRdata[15:13] == 3'h0)
		else $error("divider spare bits set");
	AST_FRAC_BACK: assert property (regWrite && regAddr == 8'h82 ##1 regRead && regAddr == 8'h82
		|=> regRdata == $past(regWdata, 2)) else $error("fraction readback wrong");
	AST_CTRL_TICK: assert property (loopCtrlTick |-> $past(oscillatorTick) || $past(oscillatorTick, 2))
		else $error("control tick without oscillator tick");
endmodule

bind flc_top flc_top_props flc_top_props_inst (.clock(clock), .rst(rst), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.oscillatorTick(oscillatorTick), .loopCtrlTick(loopCtrlTick), .dspInputDmicSel(dspInputDmicSel));

/* testbench/tb_flc_top.sv */
`timescale 1ns/1ps
module tb_flc_top;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [15:0] regWdata = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [15:0] regRdata;
	logic [5:0]  refCnt = 6'h00;
	logic        oscillatorTick;
	logic        loopCtrlTick;
	logic        loopOutputClock;
	logic        dspInputDmicSel;
	int          bad_count = 0;
	int          checks = 0;

	initial forever #50 clock = ~clock;
	// Three related reference rates from one counter: 32, 16 and 64 clocks
	always @(posedge clock) refCnt <= refCnt + 6'h01;

	flc_top flc_top_inst (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .masterClockIn(refCnt[4]),
		.bitClockIn(refCnt[3]), .frameClockIn(refCnt[5]), .oscillatorTick(oscillatorTick),
		.loopCtrlTick(loopCtrlTick), .loopOutputClock(loopOutputClock), .dspInputDmicSel(dspInputDmicSel));

	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task near(input string nm, input int s, input int e);
		chk(nm, (s >= e - 3 && s <= e + 3) ? 16'(e) : 16'(s), 16'(e));
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
		@(posedge clock);
	endtask

	task rd(input logic [7:0] a, input logic [15:0] e);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		chk("regRdata", regRdata, e);
		@(posedge clock);
	endtask

	task t_regs;
		logic [7:0]  adr [5];
		logic [15:0] msk [5];
		adr = '{8'h80, 8'h81, 8'h82, 8'h83, 8'ha4};
		msk = '{16'h0005, 16'h1fff, 16'hffff, 16'h03ff, 16'h0200};
		for (int i = 0; i < 5; i++) rd(adr[i], 16'h0000);
		for (int i = 0; i < 5; i++) wr(adr[i], 16'hffff);
		for (int i = 0; i < 5; i++) rd(adr[i], msk[i]);
		chk("dmicSel", {15'h0, dspInputDmicSel}, 16'h0001);
		wr(8'ha4, 16'hfdff);
		chk("dmicSel", {15'h0, dspInputDmicSel}, 16'h0000);
		wr(8'h84, 16'hffff);
		rd(8'h84, 16'h0000);
		regWrite <= 1'b1;
		regAddr <= 8'h82;
		regWdata <= 16'ha5c3;
		@(posedge clock);
		regWrite <= 1'b0;
		rd(8'h82, 16'ha5c3);
	endtask

	task meas(input logic [15:0] c80, input logic [15:0] d81, input logic [15:0] n, input int eo, input int ec);
		int  o;
		int  c;
		int  u;
		logic p;
		o = 0;
		c = 0;
		u = 0;
		p = 1'b0;
		wr(8'h80, c80);
		wr(8'h81, d81);
		wr(8'h83, n);
		// Three divided master clock reference periods at prediv 8
		repeat (768) @(posedge clock);
		repeat (512) begin
			@(negedge clock);
			o += int'(oscillatorTick);
			c += int'(loopCtrlTick);
			u += int'(loopOutputClock && !p);
			p = loopOutputClock;
		end
		@(posedge clock);
		near("oscTicks", o, eo);
		near("ctrlTicks", c, ec);
		near("outRises", u, eo >> (d81[5:3] + 1));
	endtask

	task t_loop;
		wr(8'h82, 16'h8000);
		meas(16'h0001, 16'h0000, 16'h0004, 64, 64);
		meas(16'h0001, 16'h0c48, 16'h0004, 32, 16);
		meas(16'h0001, 16'h1001, 16'h0003, 48, 48);
		meas(16'h0001, 16'h0604, 16'h0002, 64, 64);
		meas(16'h0001, 16'h0007, 16'h0001, 256, 256);
		meas(16'h0005, 16'h0000, 16'h0004, 72, 72);
	endtask

	task tally_and_finish;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_loop;
		tally_and_finish;
	end
endmodule
